// [hdl/fcsm_pkg.sv]
package fcsm_pkg;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;
	// host-side register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h2;
	localparam logic [3:0] REG_STAT = 4'h3;
	localparam logic [3:0] REG_RDAT = 4'h4;
	// ctrl register command codes (bits 2:0), bit 4 word mode
	localparam logic [2:0] CMD_NONE = 3'h0;
	localparam logic [2:0] CMD_READ = 3'h1;
	localparam logic [2:0] CMD_RESET = 3'h2;
	localparam logic [2:0] CMD_AUTOSEL = 3'h3;
	localparam logic [2:0] CMD_PROGRAM = 3'h4;
	localparam logic [2:0] CMD_UNPROT = 3'h5;
	localparam logic [2:0] CMD_UNPROT_END = 3'h6;
	localparam int CTRL_WORD_BIT = 4;
	// device command values; arbitrary defaults, set per part
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002AA;
	localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] AUTOSEL_DATA = 8'h90;
	localparam logic [7:0] PROGRAM_DATA = 8'hA0;
	localparam logic [7:0] RESET_DATA = 8'hF0;
	// bus phase timing
	localparam int CLK_NS = 100;
	localparam int PHASE_NS = 100;
	localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_TIMEOUT_US = 400;
	localparam int PROG_TIMEOUT_CYC = PROG_TIMEOUT_US * 1000 / CLK_NS;
	localparam int FLAG_BIT = 5;
	localparam int TOGGLE_BIT = 6;
endpackage

// [hdl/fcsm_host.sv]
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module fcsm_host (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// flash pins
	output logic [fcsm_pkg::ADDR_W-1:0] flash_addr,
	input wire logic [fcsm_pkg::DATA_W-1:0] flash_dq_in,
	output logic [fcsm_pkg::DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe,
	output logic chip_enable_n,
	output logic write_enable_n,
	output logic output_enable_n,
	output logic width_select_n,
	output logic hard_reset_n,
	output logic unprotect_hv,
	input wire logic ready_busy_n
);
	import fcsm_pkg::*;
	typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RDSTB,
		ST_RDCAP, ST_POLL, ST_GAP} fcsm_state_t;
	fcsm_state_t state;
	logic [DATA_W-1:0] dq_s1, dq_s;
	logic rb_s1, rb_s;
	logic [ADDR_W-1:0] op_addr;
	logic [DATA_W-1:0] op_data, rd_data;
	logic [2:0] op_cmd;
	logic [2:0] step;
	logic word_mode, busy, err_flag, poll_prev_valid;
	logic [DATA_W-1:0] poll_prev;
	logic [3:0] phase;
	logic [22:0] timeout;
	logic [ADDR_W-1:0] cyc_addr;
	logic [7:0] cyc_data;
	logic [2:0] n_cycles;
	logic phase_done, is_read_op, toggling;
	function automatic logic [ADDR_W-1:0] cmd_addr(input logic [2:0] s);
		cmd_addr = (s == 3'd1) ? UNLOCK2_ADDR : UNLOCK1_ADDR;
	endfunction
	assign phase_done = (phase == 4'(PHASE_CYC - 1));
	assign is_read_op = (op_cmd == CMD_READ);
	// autoselect and program: cycle addresses and data
	assign cyc_addr = (step == 3'd3) ? op_addr : cmd_addr(step);
	assign cyc_data = (step == 3'd0) ? UNLOCK1_DATA :
		(step == 3'd1) ? UNLOCK2_DATA :
		(step == 3'd3) ? op_data[7:0] :
		(op_cmd == CMD_AUTOSEL) ? AUTOSEL_DATA : PROGRAM_DATA;
	// full sequences only; reset ends autoselect
	// reset: one cycle; three cycles; four cycles
	assign n_cycles = (op_cmd == CMD_RESET) ? 3'd1 :
		(op_cmd == CMD_AUTOSEL) ? 3'd3 : 3'd4;
	assign toggling = poll_prev_valid &&
		(poll_prev[TOGGLE_BIT] != dq_s[TOGGLE_BIT]);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dq_s1 <= '0;
			dq_s <= '0;
			rb_s1 <= 1'b1;
			rb_s <= 1'b1;
		end else begin
			dq_s1 <= flash_dq_in;
			dq_s <= dq_s1;
			rb_s1 <= ready_busy_n;
			rb_s <= rb_s1;
		end
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			op_addr <= '0;
			op_data <= '0;
			word_mode <= 1'b1;
			unprotect_hv <= 1'b0;
		end else if (reg_wr && state == ST_IDLE) begin
			if (reg_addr == REG_ADDR)
				op_addr <= reg_wdata[ADDR_W-1:0];
			if (reg_addr == REG_DATA)
				op_data <= reg_wdata[DATA_W-1:0];
			if (reg_addr == REG_CTRL) begin
				word_mode <= reg_wdata[CTRL_WORD_BIT];
				// temporary unprotect level on reset pin
				if (reg_wdata[2:0] == CMD_UNPROT)
					unprotect_hv <= 1'b1;
				if (reg_wdata[2:0] == CMD_UNPROT_END)
					unprotect_hv <= 1'b0;
			end
		end
	end
	// strobes held high from reset; output enable high on writes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			op_cmd <= CMD_NONE;
			step <= 3'd0;
			phase <= 4'h0;
			busy <= 1'b0;
			err_flag <= 1'b0;
			rd_data <= '0;
			poll_prev <= '0;
			poll_prev_valid <= 1'b0;
			timeout <= '0;
			chip_enable_n <= 1'b1;
			write_enable_n <= 1'b1;
			output_enable_n <= 1'b1;
			flash_addr <= '0;
			flash_dq_out <= '0;
			flash_dq_oe <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				step <= 3'd0;
				phase <= 4'h0;
				if (reg_wr && reg_addr == REG_CTRL &&
					reg_wdata[2:0] inside {CMD_READ, CMD_RESET,
					CMD_AUTOSEL, CMD_PROGRAM}) begin
					op_cmd <= reg_wdata[2:0];
					busy <= 1'b1;
					if (reg_wdata[2:0] == CMD_PROGRAM)
						err_flag <= 1'b0;
					state <= (reg_wdata[2:0] == CMD_READ) ?
						ST_RDSTB : ST_SETUP;
				end
			end
			ST_SETUP: begin
				flash_addr <= (op_cmd == CMD_RESET) ? '0 : cyc_addr;
				flash_dq_out <= {8'h00,
					(op_cmd == CMD_RESET) ? RESET_DATA : cyc_data};
				flash_dq_oe <= 1'b1;
				output_enable_n <= 1'b1;
				state <= ST_STROBE;
			end
			ST_STROBE: begin
				chip_enable_n <= 1'b0;
				write_enable_n <= 1'b0;
				phase <= phase + 4'h1;
				if (phase_done) begin
					phase <= 4'h0;
					state <= ST_HOLD;
				end
			end
			// data stable across the rising strobe edge
			ST_HOLD: begin
				write_enable_n <= 1'b1;
				chip_enable_n <= 1'b1;
				step <= step + 3'd1;
				if (step + 3'd1 == n_cycles) begin
					// final cycle starts the program algorithm
					state <= (op_cmd == CMD_PROGRAM) ? ST_POLL : ST_GAP;
					poll_prev_valid <= 1'b0;
					timeout <= '0;
				end else begin
					state <= ST_SETUP;
				end
			end
			ST_RDSTB: begin
				flash_dq_oe <= 1'b0;
				flash_addr <= op_addr;
				chip_enable_n <= 1'b0;
				output_enable_n <= 1'b0;
				phase <= phase + 4'h1;
				if (phase == 4'(PHASE_CYC + 2)) begin
					phase <= 4'h0;
					state <= ST_RDCAP;
				end
			end
			ST_RDCAP: begin
				rd_data <= dq_s;
				chip_enable_n <= 1'b1;
				output_enable_n <= 1'b1;
				if (!is_read_op)
					poll_prev_valid <= 1'b1;
				state <= is_read_op ? ST_GAP : ST_POLL;
			end
			// no commands while busy; poll status by toggle bit
			ST_POLL: begin
				timeout <= timeout + 23'd1;
				poll_prev <= rd_data;
				if (poll_prev_valid && !toggling && rb_s) begin
					state <= ST_GAP;
				end else if (poll_prev_valid &&
					rd_data[FLAG_BIT] && toggling) begin
					// exceeded flag: restore array read by reset
					err_flag <= 1'b1;
					op_cmd <= CMD_RESET;
					step <= 3'd0;
					state <= ST_SETUP;
				end else if (timeout == 23'(PROG_TIMEOUT_CYC)) begin
					err_flag <= 1'b1;
					state <= ST_GAP;
				end else begin
					flash_addr <= op_addr;
					state <= ST_RDSTB;
				end
			end
			ST_GAP: begin
				flash_dq_oe <= 1'b0;
				busy <= 1'b0;
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
	// width select follows host word mode
	assign width_select_n = word_mode;
	// host never pulls hard reset; arst_n restart returns to idle and issues no sequence
	assign hard_reset_n = 1'b1;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= '0;
		else if (reg_rd)
			case (reg_addr)
			REG_ADDR: reg_rdata <= 32'(op_addr);
			REG_DATA: reg_rdata <= 32'(op_data);
			REG_STAT: reg_rdata <= {28'h0, unprotect_hv, rb_s,
				err_flag, busy};
			REG_RDAT: reg_rdata <= 32'(rd_data);
			REG_CTRL: reg_rdata <= {27'h0, word_mode, 1'b0, op_cmd};
			default: reg_rdata <= 32'h0;
			endcase
		else
			reg_rdata <= 32'h0;
	end
	// never strobe a write with output enable low
	a_write_oe_high: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		!write_enable_n |-> output_enable_n)
		else $error("write strobe with output enable low");
	a_prog_final: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		state == ST_HOLD && op_cmd == CMD_PROGRAM && step == 3'd3 |=>
		state == ST_POLL)
		else $error("program not entering poll after fourth cycle");
	// address and data stable while strobes low
	a_addr_stable: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		!write_enable_n |-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("address moved during write strobe");
	a_data_stable: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		$rose(write_enable_n) |-> $stable(flash_dq_out) && flash_dq_oe)
		else $error("data not held at rising strobe");
	// exceeded flag forces a reset cycle
	a_flag_reset: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		state == ST_POLL && poll_prev_valid && toggling &&
		rd_data[FLAG_BIT] |=> op_cmd == CMD_RESET ##2
		flash_dq_out[7:0] == RESET_DATA)
		else $error("no reset after exceeded flag");
	// no register command taken while busy
	a_busy_ignored: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		busy && state != ST_GAP && state != ST_IDLE |=> busy)
		else $error("busy dropped mid operation");
endmodule

// [tb/fcsm_flash_model.sv]
`timescale 1ns/1ps
module fcsm_flash_model #(
	// arbitrary identification values
	parameter logic [7:0] MAKER_CODE = 8'h3E,
	parameter logic [7:0] DEVICE_CODE = 8'h7A
) (
	// host pins
	input wire logic [fcsm_pkg::ADDR_W-1:0] addr,
	input wire logic [fcsm_pkg::DATA_W-1:0] dq_host,
	input wire logic dq_host_oe,
	output logic [fcsm_pkg::DATA_W-1:0] dq,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic byte_n,
	input wire logic hard_reset_n,
	input wire logic unprotect_hv,
	output logic ready_busy_n
);
	import fcsm_pkg::*;
	logic [15:0] mem [int];
	logic [ADDR_W-1:0] lat_a;
	logic [7:0] lat_d;
	logic [15:0] rdata = 16'hFFFF;
	logic [1:0] st = 2'h0;
	logic auto_on = 1'b0;
	logic busy = 1'b0;
	logic lim = 1'b0;
	logic pwr_ok = 1'b0;
	logic [15:0] old;
	int idx;
	wire wr_n = ce_n | we_n | ~oe_n;
	wire rd_en = ~ce_n & ~oe_n;
	assign ready_busy_n = ~busy;
	// strobes low at power-up give no command
	initial #1 pwr_ok = (wr_n === 1'b1);
	// released bus shows inverse, never a stale value
	assign dq = rd_en ? rdata : (dq_host_oe ? dq_host : ~rdata);
	function automatic logic [15:0] rd_mem(input logic [18:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
	endfunction
	always @(negedge wr_n) lat_a = addr;
	always @(posedge wr_n) begin
		lat_d = dq_host[7:0];
		// after the limit flag a reset is still taken
		if (busy && lim && lat_d == RESET_DATA) begin
			busy = 1'b0;
			lim = 1'b0;
			st = 2'h0;
		end
		// ignored at power-up and while busy
		if (pwr_ok && !busy) begin
			if (lat_d == RESET_DATA) begin
				st = 2'h0;
				auto_on = 1'b0;
			end else if (st == 2'h3) begin
				st = 2'h0;
				busy = 1'b1;
				if (lat_a[18:16] != 3'h7 || unprotect_hv) begin
					old = rd_mem(lat_a);
					// a one over a zero halts with the limit flag
					lim = |(~old[7:0] & lat_d);
					mem[int'(lat_a)] = old & {8'hFF, lat_d};
				end
				if (!lim)
					fork
						#20000 busy = 1'b0;
					join_none
			end else if (st == 2'h2 && lat_a == UNLOCK1_ADDR && lat_d == AUTOSEL_DATA) begin
				auto_on = 1'b1;
				st = 2'h0;
			end else if (st == 2'h2 && lat_a == UNLOCK1_ADDR && lat_d == PROGRAM_DATA)
				st = 2'h3;
			else if (st == 2'h1 && lat_a == UNLOCK2_ADDR && lat_d == UNLOCK2_DATA)
				st = 2'h2;
			else if (st == 2'h0 && lat_a == UNLOCK1_ADDR && lat_d == UNLOCK1_DATA)
				st = 2'h1;
			else
				st = 2'h0;
		end
		pwr_ok = 1'b1;
	end
	always @(negedge hard_reset_n) begin
		st = 2'h0;
		auto_on = 1'b0;
		busy = 1'b0;
		lim = 1'b0;
	end
	always @(posedge rd_en) begin
		// address launched with the strobe settles first
		#1;
		idx = byte_n ? int'(addr[7:0]) : int'(addr[7:1]);
		// status toggles while busy, bit 5 is the limit flag
		if (busy)
			rdata = {rdata[15:7], ~rdata[6], lim, rdata[4:0]};
		else if (auto_on && idx == 0)
			rdata = {8'h00, MAKER_CODE};
		else if (auto_on && idx == 1)
			rdata = {8'h00, DEVICE_CODE};
		else if (auto_on)
			rdata = {15'h0000, addr[18:16] == 3'h7};
		else
			rdata = rd_mem(addr);
	end
endmodule

// [tb/fcsm_host_bench.sv]
`timescale 1ns/1ps
module fcsm_host_bench;
	import fcsm_pkg::*;
	localparam logic [7:0] MAKER = 8'h3E;
	localparam logic [7:0] DEVICE = 8'h7A;
	logic sys_clk = 1'b0;
	logic arst_n, reg_wr, reg_rd;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata;
	wire [31:0] reg_rdata;
	wire [ADDR_W-1:0] fa;
	wire [DATA_W-1:0] dqi, dqo;
	wire dq_oe, ce_n, we_n, oe_n, ws_n, hr_n, uhv, rb_n;
	int fails = 0;
	int check_count = 0;
	fcsm_host dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .flash_addr(fa), .flash_dq_in(dqi),
		.flash_dq_out(dqo), .flash_dq_oe(dq_oe), .chip_enable_n(ce_n),
		.write_enable_n(we_n), .output_enable_n(oe_n), .width_select_n(ws_n),
		.hard_reset_n(hr_n), .unprotect_hv(uhv), .ready_busy_n(rb_n));
	fcsm_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) flash (
		.addr(fa), .dq_host(dqo), .dq_host_oe(dq_oe), .dq(dqi), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .byte_n(ws_n), .hard_reset_n(hr_n),
		.unprotect_hv(uhv), .ready_busy_n(rb_n));
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// word mode always set; waits on busy with a bound
	task automatic cmd(input logic [2:0] c);
		logic [31:0] s;
		wr(REG_CTRL, 32'h00000010 | {29'h0, c});
		for (int i = 0; i < 6000; i++) begin
			rd(REG_STAT, s);
			if (s[0] === 1'b0)
				break;
		end
		chk(s & 32'h1, 32'h0);
	endtask
	task automatic frd(input logic [18:0] a, output logic [7:0] b);
		logic [31:0] d;
		wr(REG_ADDR, {13'h0000, a});
		cmd(CMD_READ);
		rd(REG_RDAT, d);
		b = d[7:0];
	endtask
	task automatic prog(input logic [18:0] a, input logic [7:0] b);
		wr(REG_ADDR, {13'h0000, a});
		wr(REG_DATA, {24'h000000, b});
		cmd(CMD_PROGRAM);
	endtask
	task automatic t_reset;
		logic [31:0] s;
		rd(REG_STAT, s);
		chk(s & 32'h7, 32'h4);
		chk({29'h0, ce_n, we_n, oe_n}, 32'h7);
		chk({31'h0, ws_n}, 32'h1);
		chk({31'h0, hr_n}, 32'h1);
		wr(REG_CTRL, 32'h00000000);
		rd(REG_CTRL, s);
		chk({30'h0, s[4], ws_n}, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_ident;
		logic [7:0] b;
		cmd(CMD_AUTOSEL);
		frd(19'h00000, b);
		chk(b, MAKER);
		frd(19'h00001, b);
		chk(b, DEVICE);
		frd(19'h70002, b);
		chk(b, 32'h1);
		frd(19'h00002, b);
		chk(b, 32'h0);
		frd(19'h12300, b);
		chk(b, MAKER);
		cmd(CMD_RESET);
		frd(19'h00000, b);
		chk(b, 32'hFF);
		$display("ident test done");
	endtask
	task automatic t_prog;
		logic [7:0] b;
		logic [31:0] s;
		prog(19'h00005, 8'h3C);
		rd(REG_STAT, s);
		chk(s & 32'h2, 32'h0);
		frd(19'h00005, b);
		chk(b, 32'h3C);
		prog(19'h00005, 8'hC3);
		rd(REG_STAT, s);
		chk(s & 32'h2, 32'h2);
		frd(19'h00005, b);
		chk(b, 32'h00);
		$display("program test done");
	endtask
	task automatic t_protect;
		logic [7:0] b;
		logic [31:0] s;
		prog(19'h70010, 8'h00);
		frd(19'h70010, b);
		chk(b, 32'hFF);
		cmd(CMD_UNPROT);
		rd(REG_STAT, s);
		chk({s[3], uhv}, 32'h3);
		prog(19'h70010, 8'h00);
		frd(19'h70010, b);
		chk(b, 32'h00);
		cmd(CMD_UNPROT_END);
		chk({31'h0, uhv}, 32'h0);
		$display("protect test done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		arst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_reset;
		t_ident;
		t_prog;
		t_protect;
		give_verdict;
	end
	// generous bound: the tests need well under 20000 cycles
	initial begin
		#5000000;
		fails++;
		give_verdict;
	end
endmodule
